/* File: shared/tnc_pkg.sv */
package tnc_pkg;

   // geometry
   localparam int         TRACKS      = 9;
   localparam int         TAP_W       = 4;
   localparam int         MAP_W       = TRACKS * TAP_W;
   localparam logic [3:0] TAP_LAST    = 4'h9;

   // timing, figures in ns, counts derived from the 40 ns system clock
   localparam int CLK_NS          = 40;
   localparam int OSC_PULSE_NS    = 100;
   localparam int TAP_SPACE_CYC   = (2 * OSC_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_STROBE_NS    = 2000;
   localparam int RD_STROBE_CYC   = (RD_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_HOLD_MIN_NS  = 500;
   localparam int RD_HOLD_MIN_CYC = (RD_HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRIME_CLR_NS    = 200;
   localparam int PRIME_CLR_CYC   = (PRIME_CLR_NS + CLK_NS - 1) / CLK_NS;
   localparam int GATHER_NS       = 1000;
   localparam int GATHER_CYC      = (GATHER_NS + CLK_NS - 1) / CLK_NS;

   // register byte offsets
   localparam logic [7:0] ADDR_TAP_SPACE = 8'h00;
   localparam logic [7:0] ADDR_GATHER    = 8'h04;
   localparam logic [7:0] ADDR_HOLD      = 8'h08;
   localparam logic [7:0] ADDR_MAP_LO    = 8'h0c;
   localparam logic [7:0] ADDR_MAP_HI    = 8'h10;
   localparam logic [7:0] ADDR_STATUS    = 8'h14;

   // decoded register indices
   localparam logic [2:0] IDX_TAP_SPACE = 3'h0;
   localparam logic [2:0] IDX_GATHER    = 3'h1;
   localparam logic [2:0] IDX_HOLD      = 3'h2;
   localparam logic [2:0] IDX_MAP_LO    = 3'h3;
   localparam logic [2:0] IDX_MAP_HI    = 3'h4;
   localparam logic [2:0] IDX_STATUS    = 3'h5;
   localparam logic [2:0] IDX_NONE      = 3'h7;

   // status field positions
   localparam int ST_SLAVE_LSB = 0;
   localparam int ST_STAT_LSB  = 9;
   localparam int ST_RUN_BIT   = 18;
   localparam int ST_BUSY_BIT  = 19;

   // reset values
   localparam logic [7:0]       TAP_SPACE_RST = 8'(TAP_SPACE_CYC);
   localparam logic [15:0]      GATHER_RST    = 16'(GATHER_CYC);
   localparam logic [15:0]      HOLD_RST      = 16'(RD_HOLD_MIN_CYC);
   localparam logic [15:0]      HOLD_MIN      = 16'(RD_HOLD_MIN_CYC);
   localparam logic [15:0]      STROBE_LEN    = 16'(RD_STROBE_CYC);
   localparam logic [3:0]       PRIME_CLR_LEN = 4'(PRIME_CLR_CYC);
   localparam logic [MAP_W-1:0] MAP9_RST      = 36'h876543210;
   localparam logic [MAP_W-1:0] MAP7_RST      = 36'h654321990;
   localparam logic [TRACKS-1:0] OMIT7_MASK   = 9'h006;

   typedef enum logic [1:0] {
      RD_IDLE,
      RD_GATHER,
      RD_STROBE,
      RD_HOLD
   } tnc_rd_state_t;

endpackage

/* File: verilog/tnc_sync.sv */
`timescale 1ns/1ps
module tnc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             srst,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule // tnc_sync

/* File: verilog/tnc_channel.sv */
`timescale 1ns/1ps
// Summary of operation
// RQ1 - controller supplies track data, strobe, check reset
// RQ2 - true bit at strobe toggles track master
// RQ3 - strobe starts deskew run and oscillator
// RQ4 - ten sequential taps commit track slaves
// RQ5 - tenth tap stops deskew run
// RQ6 - write and erase only with power high
// RQ7 - prime high forces both head phases high
// RQ8 - prime release leaves flip-flops in reset
// RQ9 - prime low enables erase driver
// RQ10 - write current only while tape moves
// RQ11 - check reset clears every track master
// RQ12 - check reset starts a full deskew run
// RQ13 - prime selects read clip threshold
// RQ14 - falling peak edge sets track staticiser
// RQ15 - first set starts gather, then 2us strobe
// RQ16 - staticisers clear at least 0.5us after strobe
// RQ17 - staticisers held clear while tape stopped
// RQ18 - seven-track build omits two tracks, remaps taps
// RQ19 - deskew and read delays are cycle counts
// RQ20 - tap to track assignment is configurable
module tnc_channel
   import tnc_pkg::*;
#(
   parameter bit SEVEN_TRACK = 1'b0
) (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    srst,
   // ahb-lite slave
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic [31:0]                  hrdata,
   // write side of the connector
   input  wire logic [tnc_pkg::TRACKS-2:0] write_bit_track,
   input  wire logic                    write_bit_parity_track,
   input  wire logic                    host_write_strobe,
   input  wire logic                    check_char_reset_pulse,
   input  wire logic                    write_prime_n,
   input  wire logic                    write_power_gate,
   input  wire logic                    tape_motion,
   // read side
   input  wire logic [tnc_pkg::TRACKS-1:0] read_peak_n,
   output logic [tnc_pkg::TRACKS-1:0]   read_data,
   output logic                         read_data_strobe,
   // head drive
   output logic [tnc_pkg::TRACKS-1:0]   head_phase_a,
   output logic [tnc_pkg::TRACKS-1:0]   head_phase_b,
   output logic                         write_current_en,
   output logic                         erase_current_en,
   output logic                         clip_level_high
);
   import tnc_pkg::*;

   localparam logic [TRACKS-1:0] OMIT = SEVEN_TRACK ? OMIT7_MASK : '0;

   function automatic logic [2:0] reg_index(input logic [31:0] a);
      logic [2:0] idx;
      idx = IDX_NONE;
      if (a[31:8] == 24'h000000) begin
         case (a[7:0])
            ADDR_TAP_SPACE: idx = IDX_TAP_SPACE;
            ADDR_GATHER:    idx = IDX_GATHER;
            ADDR_HOLD:      idx = IDX_HOLD;
            ADDR_MAP_LO:    idx = IDX_MAP_LO;
            ADDR_MAP_HI:    idx = IDX_MAP_HI;
            ADDR_STATUS:    idx = IDX_STATUS;
            default:        idx = IDX_NONE;
         endcase
      end
      return idx;
   endfunction

   // pins cross into the clock domain; data and strobe see equal delay
   logic [TRACKS-1:0] wbit_s;
   logic [TRACKS-1:0] peak_n_s;
   logic              strobe_s;
   logic              ars_s;
   logic              prime_s;
   logic              power_s;
   logic              motion_s;
   logic [TRACKS-1:0] peak_s;
   logic              primed_s;

   // active-low lines cross inverted, so the cleared synchroniser shows their idle
   // level: no false peak and no false prime release right after reset
   tnc_sync #(.WIDTH(2 * TRACKS + 5)) u_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .d       ({write_bit_track, write_bit_parity_track, ~read_peak_n, host_write_strobe,
                 check_char_reset_pulse, ~write_prime_n, write_power_gate, tape_motion}),
      .q       ({wbit_s, peak_s, strobe_s, ars_s, primed_s, power_s, motion_s})
   );

   assign peak_n_s = ~peak_s;
   assign prime_s  = ~primed_s;

   // register bus
   logic [31:0]       hrdata_q, hrdata_d;
   logic [2:0]        wr_idx_q, wr_idx_d;
   logic              wr_pend_q, wr_pend_d;
   logic [7:0]        tap_space_q, tap_space_d;
   logic [15:0]       gather_q, gather_d;
   logic [15:0]       hold_q, hold_d;
   logic [MAP_W-1:0]  map_q, map_d;
   logic [31:0]       status;
   // write path and deskew
   logic [TRACKS-1:0] master_q, master_d;
   logic [TRACKS-1:0] slave_q, slave_d;
   logic [TRACKS-1:0] head_a_q, head_a_d;
   logic [TRACKS-1:0] head_b_q, head_b_d;
   logic [TRACKS-1:0] commit;
   logic [3:0]        clr_cnt_q, clr_cnt_d;
   logic              strobe_prev_q, ars_prev_q;
   logic              internal_write_strobe, ars_rise, clr_hold;
   logic              run_q, run_d;
   logic [7:0]        space_cnt_q, space_cnt_d;
   logic [3:0]        tap_q, tap_d;
   logic              tap_fire;
   logic              wcur_q, wcur_d, erase_q, erase_d, clip_q, clip_d;
   // read path
   tnc_rd_state_t     rd_state_q, rd_state_d;
   logic [15:0]       rd_cnt_q, rd_cnt_d;
   logic [TRACKS-1:0] stat_q, stat_d, peak_prev_q, stat_set;
   logic              rd_strobe_q, rd_strobe_d, hold_done;
   logic [15:0]       hold_eff;

   assign status = {12'h000, rd_state_q != RD_IDLE, run_q, stat_q, slave_q};

   always_comb begin
      logic accept;
      accept      = hsel & hready & htrans[1];
      hrdata_d    = hrdata_q;
      wr_pend_d   = accept & hwrite;
      wr_idx_d    = accept ? reg_index(haddr) : wr_idx_q;
      tap_space_d = tap_space_q;
      gather_d    = gather_q;
      hold_d      = hold_q;
      map_d       = map_q;
      if (accept && !hwrite) begin
         unique case (reg_index(haddr))
            IDX_TAP_SPACE: hrdata_d = {24'h000000, tap_space_q};
            IDX_GATHER:    hrdata_d = {16'h0000, gather_q};
            IDX_HOLD:      hrdata_d = {16'h0000, hold_q};
            IDX_MAP_LO:    hrdata_d = map_q[31:0];
            IDX_MAP_HI:    hrdata_d = {28'h0000000, map_q[MAP_W-1:32]};
            IDX_STATUS:    hrdata_d = status;
            default:       hrdata_d = 32'h00000000;
         endcase
      end
      // zero would wrap a counter to its longest count, so spacing and gather store it as one
      if (wr_pend_q) begin
         unique case (wr_idx_q)
            IDX_TAP_SPACE: tap_space_d = (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0]; // [RQ19]
            IDX_GATHER:    gather_d = (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
            IDX_HOLD:      hold_d = hwdata[15:0];
            IDX_MAP_LO:    map_d[31:0] = hwdata; // [RQ20]
            IDX_MAP_HI:    map_d[MAP_W-1:32] = hwdata[3:0];
            default:       ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         hrdata_q    <= 32'h00000000;
         wr_idx_q    <= IDX_NONE;
         wr_pend_q   <= 1'b0;
         tap_space_q <= TAP_SPACE_RST;
         gather_q    <= GATHER_RST;
         hold_q      <= HOLD_RST;
         map_q       <= SEVEN_TRACK ? MAP7_RST : MAP9_RST; // [RQ18]
      end else begin
         hrdata_q    <= hrdata_d;
         wr_idx_q    <= wr_idx_d;
         wr_pend_q   <= wr_pend_d;
         tap_space_q <= tap_space_d;
         gather_q    <= gather_d;
         hold_q      <= hold_d;
         map_q       <= map_d;
      end
   end

   // each tap strikes the tracks whose table entry names it
   for (genvar t = 0; t < TRACKS; t++) begin : g_commit
      assign commit[t] = tap_fire & (map_q[t*TAP_W +: TAP_W] == tap_q); // [RQ4] [RQ20]
   end

   assign internal_write_strobe = strobe_s & ~strobe_prev_q;
   assign ars_rise              = ars_s & ~ars_prev_q;
   assign clr_hold              = prime_s | (clr_cnt_q != 4'h0);
   assign tap_fire              = run_q & (space_cnt_q == 8'h00);

   always_comb begin
      clr_cnt_d = (clr_cnt_q != 4'h0) ? clr_cnt_q - 4'h1 : 4'h0;
      if (prime_s) begin
         clr_cnt_d = PRIME_CLR_LEN; // [RQ8]
      end
      master_d = master_q;
      if (clr_hold) begin
         master_d = '0; // [RQ8]
      end else if (ars_s) begin
         master_d = '0; // [RQ11]
      end else if (internal_write_strobe) begin
         master_d = master_q ^ wbit_s; // [RQ2]
      end
      slave_d = clr_hold ? '0 : (slave_q & ~commit) | (master_q & commit); // [RQ4]
      // deskew run: the set always wins over the tenth tap
      run_d       = run_q;
      space_cnt_d = space_cnt_q;
      tap_d       = tap_q;
      if (run_q) begin
         space_cnt_d = space_cnt_q - 8'h01;
         if (tap_fire) begin
            space_cnt_d = tap_space_q - 8'h01; // [RQ19]
            tap_d       = tap_q + 4'h1;
            if (tap_q == TAP_LAST) begin
               run_d = 1'b0; // [RQ5]
               tap_d = 4'h0;
            end
         end
      end
      if ((internal_write_strobe || ars_rise) && (!run_q || (tap_fire && tap_q == TAP_LAST))) begin
         run_d       = 1'b1; // [RQ3] [RQ12]
         space_cnt_d = tap_space_q - 8'h01;
         tap_d       = 4'h0;
      end
      if (prime_s) begin
         head_a_d = '1; // [RQ7]
         head_b_d = '1;
      end else begin
         head_a_d = slave_d | OMIT; // [RQ18]
         head_b_d = ~slave_d | OMIT;
      end
      wcur_d  = power_s & motion_s & ~clr_hold; // [RQ6] [RQ10]
      erase_d = power_s & ~prime_s; // [RQ6] [RQ9]
      clip_d  = ~prime_s; // [RQ13]
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         master_q      <= '0;
         slave_q       <= '0;
         head_a_q      <= '1;
         head_b_q      <= '1;
         clr_cnt_q     <= 4'h0;
         strobe_prev_q <= 1'b0;
         ars_prev_q    <= 1'b0;
         run_q         <= 1'b0;
         space_cnt_q   <= 8'h00;
         tap_q         <= 4'h0;
         wcur_q        <= 1'b0;
         erase_q       <= 1'b0;
         clip_q        <= 1'b0;
      end else begin
         master_q      <= master_d & ~OMIT;
         slave_q       <= slave_d & ~OMIT;
         head_a_q      <= head_a_d;
         head_b_q      <= head_b_d;
         clr_cnt_q     <= clr_cnt_d;
         strobe_prev_q <= strobe_s;
         ars_prev_q    <= ars_s;
         run_q         <= run_d;
         space_cnt_q   <= space_cnt_d;
         tap_q         <= tap_d;
         wcur_q        <= wcur_d;
         erase_q       <= erase_d;
         clip_q        <= clip_d;
      end
   end

   // read side; a peak in the clearing cycle survives, tape stop clears all
   assign hold_eff  = (hold_q < HOLD_MIN) ? HOLD_MIN : hold_q;
   assign stat_set  = ~peak_n_s & peak_prev_q & ~OMIT; // [RQ14] [RQ18]
   assign hold_done = (rd_state_q == RD_HOLD) & (rd_cnt_q == 16'h0000);

   always_comb begin
      rd_state_d  = rd_state_q;
      rd_cnt_d    = rd_cnt_q;
      rd_strobe_d = rd_strobe_q;
      unique case (rd_state_q)
         RD_IDLE: begin
            if (stat_q != '0) begin
               rd_state_d = RD_GATHER; // [RQ15]
               rd_cnt_d   = gather_q - 16'h0001; // [RQ19]
            end
         end
         RD_GATHER: begin
            rd_cnt_d = rd_cnt_q - 16'h0001;
            if (rd_cnt_q == 16'h0000) begin
               rd_state_d  = RD_STROBE;
               rd_cnt_d    = STROBE_LEN - 16'h0001; // [RQ15]
               rd_strobe_d = 1'b1;
            end
         end
         RD_STROBE: begin
            rd_cnt_d = rd_cnt_q - 16'h0001;
            if (rd_cnt_q == 16'h0000) begin
               rd_state_d  = RD_HOLD;
               rd_cnt_d    = hold_eff - 16'h0001; // [RQ16]
               rd_strobe_d = 1'b0;
            end
         end
         RD_HOLD: begin
            rd_cnt_d = rd_cnt_q - 16'h0001;
            if (hold_done) begin
               rd_state_d = RD_IDLE; // [RQ16]
            end
         end
      endcase
      stat_d = (stat_q & ~{TRACKS{hold_done}}) | stat_set;
      if (!motion_s) begin
         stat_d      = '0; // [RQ17]
         rd_state_d  = RD_IDLE;
         rd_strobe_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_state_q  <= RD_IDLE;
         rd_cnt_q    <= 16'h0000;
         rd_strobe_q <= 1'b0;
         stat_q      <= '0;
         peak_prev_q <= '1;
      end else begin
         rd_state_q  <= rd_state_d;
         rd_cnt_q    <= rd_cnt_d;
         rd_strobe_q <= rd_strobe_d;
         stat_q      <= stat_d;
         peak_prev_q <= peak_n_s;
      end
   end

   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign hrdata           = hrdata_q;
   assign read_data        = stat_q;
   assign read_data_strobe = rd_strobe_q;
   assign head_phase_a     = head_a_q;
   assign head_phase_b     = head_b_q;
   assign write_current_en = wcur_q;
   assign erase_current_en = erase_q;
   assign clip_level_high  = clip_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_prime_forces_high: assert property (prime_s |=> (&head_a_q && &head_b_q)) // [RQ7]
      else $error("head phases not both high under prime");
   a_prime_release_reset: assert property ($fell(prime_s) |-> ##1 (master_q == '0)[*4]) // [RQ8]
      else $error("flip-flops not held reset after prime release");
   a_erase_needs_power: assert property (erase_current_en |-> $past(power_s) && !$past(prime_s)) // [RQ6] [RQ9]
      else $error("erase driven without power or prime");
   a_wcur_needs_motion: assert property (!motion_s |=> !write_current_en) // [RQ10]
      else $error("write current while tape stopped");
   a_strobe_toggles: assert property (internal_write_strobe && !clr_hold && !ars_s
      |=> master_q == ($past(master_q) ^ ($past(wbit_s) & ~OMIT))) // [RQ2]
      else $error("master did not toggle on strobe");
   a_check_char_clear: assert property (ars_s && !prime_s |=> master_q == '0) // [RQ11]
      else $error("check reset left a master set");
   a_deskew_start: assert property ((internal_write_strobe || ars_rise) |=> run_q) // [RQ3] [RQ12]
      else $error("deskew run not started");
   a_deskew_stop: assert property (tap_fire && tap_q == TAP_LAST && !internal_write_strobe
      && !ars_rise |=> !run_q) // [RQ5]
      else $error("deskew run not stopped by last tap");
   a_stopped_clear: assert property (!motion_s |=> read_data == '0) // [RQ17]
      else $error("staticisers not clear while tape stopped");
   a_strobe_width: assert property (@(posedge sys_clk) disable iff (srst || !motion_s)
      $rose(rd_strobe_q) |-> ##49 rd_strobe_q ##1 !rd_strobe_q) // [RQ15]
      else $error("read strobe width wrong");
   a_hold_after_strobe: assert property ($fell(rd_strobe_q) && motion_s
      |-> (!hold_done)[*8] ##1 (!hold_done)[*4]) // [RQ16]
      else $error("staticisers cleared too soon after strobe");

   c_write_char: cover property (internal_write_strobe ##[1:100] (tap_fire && tap_q == TAP_LAST));
   c_check_char: cover property (ars_rise ##1 run_q);
   c_read_char: cover property ($rose(rd_strobe_q) ##[1:200] hold_done);

endmodule // tnc_channel

/* File: tb/tnc_ctrl_model.sv */
`timescale 1ns/1ps
module tnc_ctrl_model
   import tnc_pkg::*;
(
   // clock
   input  wire logic                  sys_clk,
   // connector lines toward the channel
   output logic [tnc_pkg::TRACKS-2:0] write_bit_track,
   output logic                       write_bit_parity_track,
   output logic                       host_write_strobe,
   output logic                       check_char_reset_pulse,
   output logic                       write_prime_n
);
   initial begin
      write_bit_track = '0;
      write_bit_parity_track = 1'b0;
      host_write_strobe = 1'b0;
      check_char_reset_pulse = 1'b0;
      write_prime_n = 1'b1;
   end

   // data leads the strobe by a cycle and holds until the strobe drops
   task automatic send_char(input logic [TRACKS-1:0] bits, input int hold);
      @(posedge sys_clk);
      write_bit_parity_track <= bits[0];
      write_bit_track <= bits[TRACKS-1:1];
      @(posedge sys_clk);
      host_write_strobe <= 1'b1;
      repeat (hold) @(posedge sys_clk);
      host_write_strobe <= 1'b0;
      // released lines flip so a late sample shows up as a wrong track
      write_bit_parity_track <= ~bits[0];
      write_bit_track <= ~bits[TRACKS-1:1];
   endtask

   task automatic send_check(input int hold);
      @(posedge sys_clk);
      check_char_reset_pulse <= 1'b1;
      repeat (hold) @(posedge sys_clk);
      check_char_reset_pulse <= 1'b0;
   endtask

   task automatic set_prime(input logic v);
      @(posedge sys_clk);
      write_prime_n <= v;
   endtask
endmodule // tnc_ctrl_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import tnc_pkg::*;
   logic              sys_clk, srst, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic [TRACKS-2:0] write_bit_track;
   logic              write_bit_parity_track, host_write_strobe, check_char_reset_pulse;
   logic              write_prime_n, write_power_gate, tape_motion, seen;
   logic [TRACKS-1:0] read_peak_n, read_data, head_phase_a, head_phase_b, slave_m;
   logic              read_data_strobe, write_current_en, erase_current_en, clip_level_high;
   int                failures, cmp_count, spc, gth, seed, k;
   logic [31:0]       ra [7] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h14, 32'h18};
   logic [31:0]       rv [7];

   assign hready = hreadyout;

   tnc_channel i_tnc_channel (
      .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .write_bit_track(write_bit_track), .write_bit_parity_track(write_bit_parity_track),
      .host_write_strobe(host_write_strobe), .check_char_reset_pulse(check_char_reset_pulse),
      .write_prime_n(write_prime_n), .write_power_gate(write_power_gate),
      .tape_motion(tape_motion), .read_peak_n(read_peak_n), .read_data(read_data),
      .read_data_strobe(read_data_strobe), .head_phase_a(head_phase_a),
      .head_phase_b(head_phase_b), .write_current_en(write_current_en),
      .erase_current_en(erase_current_en), .clip_level_high(clip_level_high));

   tnc_ctrl_model i_tnc_ctrl_model (
      .sys_clk(sys_clk), .write_bit_track(write_bit_track),
      .write_bit_parity_track(write_bit_parity_track), .host_write_strobe(host_write_strobe),
      .check_char_reset_pulse(check_char_reset_pulse), .write_prime_n(write_prime_n));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d, failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      r = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask

   // watch each track's first change to see the deskew order and spacing
   task automatic wr_op(input logic chkc, input logic [TRACKS-1:0] bits);
      logic [TRACKS-1:0] nxt;
      int ct [TRACKS];
      int t0;
      int hold;
      hold = 3 + ($unsigned($random(seed)) % 4);
      nxt = chkc ? '0 : slave_m ^ bits;
      foreach (ct[t]) ct[t] = -1;
      if (chkc)
         fork i_tnc_ctrl_model.send_check(hold); join_none
      else
         fork i_tnc_ctrl_model.send_char(bits, hold); join_none
      for (int n = 0; n < 12 * spc + 20; n++) begin
         @(posedge sys_clk);
         #1;
         foreach (ct[t]) if (ct[t] < 0 && head_phase_a[t] !== slave_m[t]) ct[t] = n;
      end
      t0 = -1;
      foreach (ct[t]) if (nxt[t] != slave_m[t]) begin
         if (t0 < 0) t0 = t;
         chk("commit_gap", (t - t0) * spc, ct[t] - ct[t0]);
      end
      chk("head_phase_a", nxt, head_phase_a);
      chk("head_phase_b", nxt ^ 9'h1ff, head_phase_b);
      slave_m = nxt;
      ahb(1'b0, 32'(ADDR_STATUS), 32'h0, rd);
      chk("status_run", 32'h0, 32'(rd[ST_RUN_BIT]));
      chk("status_slave", 32'(slave_m), 32'(rd[8:0]));
   endtask

   task automatic rd_char(input logic [TRACKS-1:0] bits);
      int n;
      for (int t = 0; t < TRACKS; t++) begin
         @(posedge sys_clk);
         read_peak_n[t] <= ~bits[t];
      end
      n = TRACKS - 1;
      while (read_data_strobe !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         if (n == TRACKS + 2) read_peak_n <= '1;
         #1;
         n++;
      end
      chk("gather_time", 32'h1, 32'(n >= gth + 3 && n <= gth + 8));
      chk("read_data", 32'(bits), 32'(read_data));
      n = 0;
      while (read_data_strobe === 1'b1 && n < 200) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("strobe_width", 32'(STROBE_LEN), n);
      n = 0;
      while (read_data === bits && n < 100) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("data_hold", 32'h1, 32'(n >= 13 && n <= 16));
      chk("read_clear", 32'h0, 32'(read_data));
   endtask

   initial begin
      seed = 32'h8235c6ac;
      failures = 0;
      cmp_count = 0;
      spc = 5;
      gth = 25;
      slave_m = '0;
      srst = 1'b1;
      hsel = 1'b0;
      htrans = 2'b00;
      hsize = 3'b010;
      haddr = '0;
      hwrite = 1'b0;
      hwdata = '0;
      write_power_gate = 1'b0;
      tape_motion = 1'b0;
      read_peak_n = '1;
      rv = '{32'(TAP_SPACE_RST), 32'(GATHER_RST), 32'(HOLD_RST), MAP9_RST[31:0],
             32'(MAP9_RST[35:32]), 32'h0, 32'h0};
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("head_phase_a", 32'h1ff, 32'(head_phase_a));
      chk("head_phase_b", 32'h1ff, 32'(head_phase_b));
      foreach (ra[i]) begin
         ahb(1'b0, ra[i], 32'h0, rd);
         chk("reg_reset", rv[i], rd);
      end
      ahb(1'b1, 32'h18, 32'hffffffff, rd);
      ahb(1'b0, 32'h18, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      ahb(1'b1, 32'(ADDR_GATHER), 32'd20, rd);
      gth = 20;
      ahb(1'b0, 32'(ADDR_GATHER), 32'h0, rd);
      chk("gather_reg", 32'd20, rd);
      // prime high for the first four combinations of power and motion, low after
      for (int j = 0; j < 8; j++) begin
         if (j == 4) i_tnc_ctrl_model.set_prime(1'b0);
         @(posedge sys_clk);
         write_power_gate <= j[0];
         tape_motion <= j[1];
         repeat (10) @(posedge sys_clk);
         #1;
         chk("erase_en", 32'(j[2] & j[0]), 32'(erase_current_en));
         chk("clip", 32'(j[2]), 32'(clip_level_high));
         if (j[2]) chk("write_en", 32'(j[0] & j[1]), 32'(write_current_en));
         if (j == 4) chk("primed", 32'h0, 32'(head_phase_a));
      end
      for (int i = 0; i < 10; i++) begin
         if (i == 5) begin
            ahb(1'b1, 32'(ADDR_TAP_SPACE), 32'd3, rd);
            spc = 3;
            ahb(1'b0, 32'(ADDR_TAP_SPACE), 32'h0, rd);
            chk("spacing_reg", 32'd3, rd);
         end
         wr_op(i == 4 || i == 9, 9'($random(seed)));
      end
      i_tnc_ctrl_model.set_prime(1'b1);
      repeat (8) @(posedge sys_clk);
      #1;
      chk("unprimed", 32'h1ff, 32'(head_phase_a & head_phase_b));
      for (int i = 0; i < 4; i++) rd_char(9'($random(seed)) | 9'h1);
      // motion drops in mid-character: nothing may reach the host
      @(posedge sys_clk);
      read_peak_n[3] <= 1'b0;
      repeat (5) @(posedge sys_clk);
      tape_motion <= 1'b0;
      seen = 1'b0;
      for (k = 0; k < 60; k++) begin
         @(posedge sys_clk);
         #1;
         if (read_data_strobe !== 1'b0) seen = 1'b1;
      end
      chk("abort_strobe", 32'h0, 32'(seen));
      chk("abort_data", 32'h0, 32'(read_data));
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      stop_test();
   end
endmodule // tb
